// ### hdl/hbridge_fault_protection_regs.vh
// Purpose: constants for the h-bridge fault protection block
// Assumes: 125 MHz clock, AXI4-Lite register access with 32-bit data
// Notes:   times are kept in their own unit, cycle counts derive from them
`ifndef HBRIDGE_FAULT_PROTECTION_REGS_VH
`define HBRIDGE_FAULT_PROTECTION_REGS_VH

// clock rate, sized to the timer width so derived counts need no cut
`define CLK_MHZ              20'd125

// protection and drive timing, in printed units
`define DEGLITCH_NS          20'd1500
`define LOCKOUT_US           20'd3000
`define WAKE_HOLD_US         20'd5
`define WAKE_DELAY_US        20'd50
`define SLEEP_US             20'd1000
`define DECAY_OFF_US         20'd25
`define DEAD_NS              20'd220

// derived cycle counts; least times round up, the rest are exact
`define DEGLITCH_CYC         ((`DEGLITCH_NS * `CLK_MHZ + 20'd999) / 20'd1000)
`define LOCKOUT_CYC          (`LOCKOUT_US * `CLK_MHZ)
`define WAKE_HOLD_CYC        (`WAKE_HOLD_US * `CLK_MHZ)
`define WAKE_DELAY_CYC       (`WAKE_DELAY_US * `CLK_MHZ)
`define SLEEP_CYC            (`SLEEP_US * `CLK_MHZ)
`define DECAY_OFF_CYC        (`DECAY_OFF_US * `CLK_MHZ)
`define DEAD_CYC             ((`DEAD_NS * `CLK_MHZ + 20'd999) / 20'd1000)

// counter width shared by all interval timers
`define TIMER_W              20

// register byte offsets
`define ADDR_W               4
`define REG_CONTROL          4'h0
`define REG_STATUS           4'h4
`define REG_TRIP_COUNT       4'h8

// control fields and reset value
`define CTRL_REGULATE_BIT    0
`define CTRL_SLEEP_EN_BIT    1
`define CTRL_RESET           2'h3

// status fields
`define STAT_UNDERVOLT_BIT   0
`define STAT_THERMAL_BIT     1
`define STAT_LOCKOUT_BIT     2
`define STAT_SLEEP_BIT       3
`define STAT_WAKE_BIT        4
`define STAT_DECAY_BIT       5
`define STAT_DEAD_BIT        6
`define STAT_GATES_LSB       8

// gate vector layout {high_a, low_a, high_b, low_b}
`define GATES_OFF            4'h0
`define GATES_COAST          4'h0
`define GATES_REVERSE        4'h6
`define GATES_FORWARD        4'h9
`define GATES_BRAKE          4'h5

// axi responses
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// ### hdl/hold_counter.v
// Purpose: counts consecutive cycles of a run level and flags a limit
// Assumes: synchronous active-high reset, limit of at least one
// Notes:   count saturates at the limit and clears as soon as run drops
`include "hbridge_fault_protection_regs.vh"

module hold_counter (
  // clock and reset
  input  wire                   clock,
  input  wire                   rst,
  // count control
  input  wire                   run,
  input  wire [`TIMER_W-1:0]    limit,
  // limit reached after limit consecutive run cycles
  output reg                    reached
);

  reg  [`TIMER_W-1:0] count_q;
  reg  [`TIMER_W-1:0] count_d;

  // saturating run-length count
  always @* begin
    if (!run) begin
      count_d = {`TIMER_W{1'b0}};
    end else if (count_q >= limit) begin
      count_d = count_q;
    end else begin
      count_d = count_q + {{(`TIMER_W-1){1'b0}}, 1'b1};
    end
  end

  // count and flag registers
  always @(posedge clock) begin
    if (rst) begin
      count_q <= {`TIMER_W{1'b0}};
      reached <= 1'b0;
    end else begin
      count_q <= count_d;
      reached <= run && (count_d >= limit);
    end
  end

endmodule // hold_counter

// ### hdl/hbridge_fault_protection.v
// Purpose: fault protection, input decoding and gate timing of an h-bridge
// Assumes: comparator flags and drive inputs are synchronous to clock
// Notes:   gate outputs are registered; all faults force every gate off
`include "hbridge_fault_protection_regs.vh"

module hbridge_fault_protection #(
  parameter [`TIMER_W-1:0] LOCKOUT_CYCLES    = `LOCKOUT_CYC,
  parameter [`TIMER_W-1:0] WAKE_DELAY_CYCLES = `WAKE_DELAY_CYC,
  parameter [`TIMER_W-1:0] SLEEP_CYCLES      = `SLEEP_CYC
) (
  // clock and reset
  input  wire                  clock,
  input  wire                  rst,
  // drive inputs from the host
  input  wire                  drive_input_a,
  input  wire                  drive_input_b,
  // analog comparator flags
  input  wire                  supply_low_lockout,
  input  wire                  overcurrent_guard,
  input  wire                  thermal_shutdown,
  input  wire                  thermal_cooled,
  input  wire                  regulation_trip,
  // gate drives of the two half-bridges
  output reg                   gate_high_a,
  output reg                   gate_low_a,
  output reg                   gate_high_b,
  output reg                   gate_low_b,
  // state
  output reg                   fault_active,
  output reg                   sleeping,
  // axi4-lite write address
  input  wire [`ADDR_W-1:0]    s_axi_awaddr,
  input  wire                  s_axi_awvalid,
  output reg                   s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]           s_axi_wdata,
  input  wire [3:0]            s_axi_wstrb,
  input  wire                  s_axi_wvalid,
  output reg                   s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]            s_axi_bresp,
  output reg                   s_axi_bvalid,
  input  wire                  s_axi_bready,
  // axi4-lite read address
  input  wire [`ADDR_W-1:0]    s_axi_araddr,
  input  wire                  s_axi_arvalid,
  output reg                   s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]           s_axi_rdata,
  output reg  [1:0]            s_axi_rresp,
  output reg                   s_axi_rvalid,
  input  wire                  s_axi_rready
);

  // one-hot operating states
  localparam [3:0] ST_SLEEP   = 4'h1;
  localparam [3:0] ST_WAKE    = 4'h2;
  localparam [3:0] ST_RUN     = 4'h4;
  localparam [3:0] ST_LOCKOUT = 4'h8;

  localparam [`TIMER_W-1:0] DEGLITCH_LIM  = `DEGLITCH_CYC;
  localparam [`TIMER_W-1:0] WAKE_HOLD_LIM = `WAKE_HOLD_CYC;
  localparam [`TIMER_W-1:0] DECAY_LIM     = `DECAY_OFF_CYC;
  localparam [`TIMER_W-1:0] DEAD_LIM      = `DEAD_CYC;

  // register address decode, shared by read and write paths
  function addr_hit;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] offset;
    begin
      addr_hit = (addr[`ADDR_W-1:2] == offset[`ADDR_W-1:2]);
    end
  endfunction

  // input pair to gate vector
  function [3:0] decode_inputs;
    input a;
    input b;
    begin
      case ({a, b})
        2'h1:    decode_inputs = `GATES_REVERSE;
        2'h2:    decode_inputs = `GATES_FORWARD;
        2'h3:    decode_inputs = `GATES_BRAKE;
        default: decode_inputs = `GATES_COAST;
      endcase
    end
  endfunction

  reg  [3:0]          state_q;
  reg  [3:0]          state_d;
  reg                 thermal_q;
  reg                 decay_q;
  reg                 dead_q;
  reg  [3:0]          gates_q;
  reg  [3:0]          target_d;
  reg  [1:0]          ctrl_q;
  reg  [31:0]         trip_count_q;
  reg  [`ADDR_W-1:0]  awaddr_q;
  reg  [31:0]         wdata_q;
  reg  [3:0]          wstrb_q;
  wire                deglitch_done;
  wire                lockout_done;
  wire                wake_hold_done;
  wire                wake_delay_done;
  wire                sleep_done;
  wire                decay_done;
  wire                dead_done;
  wire                any_input;
  wire                hard_fault;
  wire                write_fire;
  wire [31:0]         status_word;

  assign any_input  = drive_input_a | drive_input_b;
  assign hard_fault = supply_low_lockout | thermal_q;
  assign write_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // interval timers: deglitch, lockout, wake, sleep, decay, dead gap
  // deglitch run length
  hold_counter u_deglitch (
    .clock   (clock),
    .rst     (rst),
    .run     (overcurrent_guard && state_q[2]),
    .limit   (DEGLITCH_LIM),
    .reached (deglitch_done)
  );
  hold_counter u_lockout (
    .clock   (clock),
    .rst     (rst),
    .run     (state_q[3] && !lockout_done),
    .limit   (LOCKOUT_CYCLES),
    .reached (lockout_done)
  );
  hold_counter u_wake_hold (
    .clock   (clock),
    .rst     (rst),
    .run     (state_q[0] && any_input),
    .limit   (WAKE_HOLD_LIM),
    .reached (wake_hold_done)
  );
  hold_counter u_wake_delay (
    .clock   (clock),
    .rst     (rst),
    .run     (state_q[1] && !wake_delay_done),
    .limit   (WAKE_DELAY_CYCLES),
    .reached (wake_delay_done)
  );
  hold_counter u_sleep (
    .clock   (clock),
    .rst     (rst),
    .run     (state_q[2] && !any_input && ctrl_q[`CTRL_SLEEP_EN_BIT]),
    .limit   (SLEEP_CYCLES),
    .reached (sleep_done)
  );
  hold_counter u_decay (
    .clock   (clock),
    .rst     (rst),
    .run     (decay_q),
    .limit   (DECAY_LIM),
    .reached (decay_done)
  );
  hold_counter u_dead (
    .clock   (clock),
    .rst     (rst),
    .run     (dead_q),
    .limit   (DEAD_LIM),
    .reached (dead_done)
  );

  // operating state sequence
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_SLEEP: begin
        if (wake_hold_done) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (wake_delay_done) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (deglitch_done) begin
          state_d = ST_LOCKOUT;
        end else if (sleep_done) begin
          state_d = ST_SLEEP;
        end
      end
      ST_LOCKOUT: begin
        if (lockout_done) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_SLEEP;
    endcase
  end

  // target gates before dead-gap timing
  always @* begin
    target_d = `GATES_OFF;
    if (hard_fault || !state_q[2]) begin
      target_d = `GATES_OFF;
    end else if (decay_q) begin
      target_d = `GATES_BRAKE;
    end else begin
      target_d = decode_inputs(drive_input_a, drive_input_b);
    end
  end

  // state, thermal latch and regulation decay
  always @(posedge clock) begin
    if (rst) begin
      state_q   <= ST_SLEEP;
      thermal_q <= 1'b0;
      decay_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      if (thermal_shutdown) begin
        thermal_q <= 1'b1;
      end else if (thermal_cooled) begin
        thermal_q <= 1'b0;
      end
      if (!state_q[2] || hard_fault) begin
        decay_q <= 1'b0;
      end else if (decay_done) begin
        decay_q <= 1'b0;
      end else if (regulation_trip && ctrl_q[`CTRL_REGULATE_BIT]) begin
        decay_q <= 1'b1;
      end
    end
  end

  // gate application with dead gap
  always @(posedge clock) begin
    if (rst) begin
      gates_q <= `GATES_OFF;
      dead_q  <= 1'b0;
    end else if (gates_q == target_d) begin
      dead_q <= 1'b0;
    end else if (target_d == `GATES_OFF) begin
      gates_q <= `GATES_OFF;
      dead_q  <= 1'b0;
    end else if (!dead_q) begin
      gates_q <= `GATES_OFF;
      dead_q  <= 1'b1;
    end else if (dead_done) begin
      gates_q <= target_d;
      dead_q  <= 1'b0;
    end
  end

  // registered pin and state outputs
  always @(posedge clock) begin
    if (rst) begin
      gate_high_a  <= 1'b0;
      gate_low_a   <= 1'b0;
      gate_high_b  <= 1'b0;
      gate_low_b   <= 1'b0;
      fault_active <= 1'b0;
      sleeping     <= 1'b1;
    end else begin
      gate_high_a  <= gates_q[3];
      gate_low_a   <= gates_q[2];
      gate_high_b  <= gates_q[1];
      gate_low_b   <= gates_q[0];
      fault_active <= hard_fault | state_q[3];
      sleeping     <= state_q[0];
    end
  end

  assign status_word = {16'h0000, 4'h0, gates_q, 1'b0, dead_q, decay_q,
                        state_q[1], state_q[0], state_q[3], thermal_q,
                        supply_low_lockout};

  // write channels, taken in either order, answered once both are held
  always @(posedge clock) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      awaddr_q      <= {`ADDR_W{1'b0}};
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      ctrl_q        <= `CTRL_RESET;
      trip_count_q  <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (write_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        if (addr_hit(awaddr_q, `REG_CONTROL)) begin
          if (wstrb_q[0]) begin
            ctrl_q <= wdata_q[1:0];
          end
        end else if (!addr_hit(awaddr_q, `REG_TRIP_COUNT) &&
                     !addr_hit(awaddr_q, `REG_STATUS)) begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      // lockout entries counted; a new entry wins over a clearing write
      if (state_q[2] && deglitch_done) begin
        trip_count_q <= trip_count_q + 32'h00000001;
      end else if (write_fire && addr_hit(awaddr_q, `REG_TRIP_COUNT)) begin
        trip_count_q <= 32'h00000000;
      end
    end
  end

  // read channel, one cycle from address to data
  always @(posedge clock) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `RESP_OKAY;
      if (addr_hit(s_axi_araddr, `REG_CONTROL)) begin
        s_axi_rdata <= {30'h00000000, ctrl_q};
      end else if (addr_hit(s_axi_araddr, `REG_STATUS)) begin
        s_axi_rdata <= status_word;
      end else if (addr_hit(s_axi_araddr, `REG_TRIP_COUNT)) begin
        s_axi_rdata <= trip_count_q;
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // hbridge_fault_protection

// ### sim/hbridge_fault_checker_assertions.sv
// Purpose: concurrent checks on gate outputs and bus answers
// Assumes: synchronous active-high reset on clock
// Notes:   gate vector is {high_a, low_a, high_b, low_b}
module hbridge_fault_checker (
  // clock and reset
  input logic        clock,
  input logic        rst,
  // fault flags
  input logic        supply_low_lockout,
  input logic        thermal_shutdown,
  // gates and state
  input logic        gate_high_a,
  input logic        gate_low_a,
  input logic        gate_high_b,
  input logic        gate_low_b,
  input logic        fault_active,
  input logic        sleeping,
  // bus answers
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [3:0] g = {gate_high_a, gate_low_a, gate_high_b, gate_low_b};
  logic [4:0] off_run;
  // length of the present all-off run at the pins, saturating
  always_ff @(posedge clock) begin
    if (rst) off_run <= 5'h1f;
    else if (g != 4'h0) off_run <= 5'h00;
    else if (off_run != 5'h1f) off_run <= off_run + 5'h01;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_supply_low_off: assert property (supply_low_lockout [*3] |=> g == 4'h0)
    else $error("gate on while supply low");
  a_thermal_off: assert property (thermal_shutdown [*3] |=> g == 4'h0)
    else $error("gate on while hot");
  a_fault_over_all: assert property (fault_active [*3] |-> g == 4'h0)
    else $error("gate on during fault");
  a_half_a_exclusive: assert property (!(gate_high_a && gate_low_a))
    else $error("half bridge a shoot through");
  a_half_b_exclusive: assert property (!(gate_high_b && gate_low_b))
    else $error("half bridge b shoot through");
  a_dead_gap: assert property (g != $past(g) && g != 4'h0 |-> $past(g) == 4'h0)
    else $error("drive change without gap");
  a_gap_length: assert property (g != 4'h0 && $past(g) == 4'h0 |-> off_run >= 5'd28)
    else $error("dead gap too short");
  a_legal_code: assert property (g inside {4'h0, 4'h5, 4'h6, 4'h9})
    else $error("gate pattern not a decoded state");
  a_sleep_off: assert property (sleeping [*3] |-> g == 4'h0)
    else $error("gate on while asleep");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
endmodule // hbridge_fault_checker

bind hbridge_fault_protection hbridge_fault_checker u_chk (
  .clock(clock), .rst(rst), .supply_low_lockout(supply_low_lockout),
  .thermal_shutdown(thermal_shutdown), .gate_high_a(gate_high_a), .gate_low_a(gate_low_a),
  .gate_high_b(gate_high_b), .gate_low_b(gate_low_b), .fault_active(fault_active),
  .sleeping(sleeping), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp));

// ### sim/host_drive_model.sv
// Purpose: host controller driving the two drive inputs
// Assumes: inputs change right after a rising clock edge
// Notes:   pwm period is sixteen cycles, off part is brake
module host_drive_model (
  // clock and reset
  input  logic       clock,
  input  logic       rst,
  // requested state and duty in sixteenths
  input  logic [1:0] code,
  input  logic       pwm_on,
  input  logic [3:0] duty,
  // drive inputs toward the bridge
  output logic       drive_input_a,
  output logic       drive_input_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] phase_q;
  // pwm phase counter
  always_ff @(posedge clock) begin
    if (rst) phase_q <= 4'h0;
    else phase_q <= phase_q + 4'h1;
  end
  // one input pulsed, brake when off
  always_ff @(posedge clock) begin
    if (rst) {drive_input_a, drive_input_b} <= 2'b00;
    else if (!pwm_on || phase_q < duty) {drive_input_a, drive_input_b} <= code;
    else {drive_input_a, drive_input_b} <= 2'b11;
  end
endmodule // host_drive_model

// ### sim/tb.sv
// Purpose: self-checking bench for the h-bridge fault protection block
// Assumes: shortened lockout, wake and sleep counts
// Notes:   every bus wait is bounded
`include "hbridge_fault_protection_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LOCK = 200;
  logic        clock, rst, supply_low_lockout, overcurrent_guard, thermal_shutdown;
  logic        thermal_cooled, regulation_trip, pwm_on, drive_input_a, drive_input_b;
  logic        gate_high_a, gate_low_a, gate_high_b, gate_low_b, fault_active, sleeping;
  logic        awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [1:0]  code, bresp, rresp, r;
  logic [3:0]  duty, awa, ara, ws;
  logic [31:0] wd, rd, d;
  int          n_mismatch, checks_done, n;
  logic [1:0]  cl [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
  logic [3:0]  gl [4] = '{`GATES_COAST, `GATES_REVERSE, `GATES_BRAKE, `GATES_FORWARD};

  host_drive_model host (.clock(clock), .rst(rst), .code(code), .pwm_on(pwm_on),
    .duty(duty), .drive_input_a(drive_input_a), .drive_input_b(drive_input_b));
  hbridge_fault_protection #(.LOCKOUT_CYCLES(20'd200), .WAKE_DELAY_CYCLES(20'd20),
    .SLEEP_CYCLES(20'd100)) uut (.clock(clock), .rst(rst), .drive_input_a(drive_input_a),
    .drive_input_b(drive_input_b), .supply_low_lockout(supply_low_lockout),
    .overcurrent_guard(overcurrent_guard), .thermal_shutdown(thermal_shutdown),
    .thermal_cooled(thermal_cooled), .regulation_trip(regulation_trip),
    .gate_high_a(gate_high_a), .gate_low_a(gate_low_a), .gate_high_b(gate_high_b),
    .gate_low_b(gate_low_b), .fault_active(fault_active), .sleeping(sleeping),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr));

  // clock generation
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_gates(input logic [3:0] exp);
    check("gates", {28'h0, exp}, {28'h0, gate_high_a, gate_low_a, gate_high_b, gate_low_b});
  endtask
  task automatic done(input string name);
    $display("test %s done", name);
  endtask
  // bus write, address and data offered together, bready held until the answer
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] dat, output logic [1:0] rsp);
    int k;
    k = 0;
    awa <= a;
    awv <= 1'b1;
    wd <= dat;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clock);
      k++;
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv && k < 100);
    rsp = bresp;
    br <= 1'b0;
    if (k >= 100) n_mismatch++;
    @(posedge clock);
  endtask
  // bus read, rready held from the request until the answer
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] dat, output logic [1:0] rsp);
    int k;
    k = 0;
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clock);
      k++;
      if (arr) arv <= 1'b0;
    end while (!rv && k < 100);
    dat = rd;
    rsp = rresp;
    rr <= 1'b0;
    if (k >= 100) n_mismatch++;
    @(posedge clock);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic oc_trip;
    overcurrent_guard <= 1'b1;
    cyc(LOCK);
    overcurrent_guard <= 1'b0;
    n = 0;
    while (fault_active && n < 1000) begin cyc(1); n++; end
  endtask

  // watchdog
  initial begin
    cyc(30000);
    n_mismatch++;
    print_verdict;
  end
  // main sequence
  initial begin
    {supply_low_lockout, overcurrent_guard, thermal_shutdown, thermal_cooled} = 4'h0;
    {regulation_trip, pwm_on, awv, wv, br, arv, rr} = 7'h0;
    {code, duty, awa, ara, wd} = 46'h0;
    ws = 4'hf;
    rst = 1'b1;
    cyc(4);
    rst <= 1'b0;
    cyc(1);
    axi_rd(`REG_CONTROL, d, r); check("control", 32'h3, d);
    axi_rd(4'hc, d, r); check("rresp", {30'h0, `RESP_SLVERR}, {30'h0, r});
    axi_wr(4'hc, 32'h0, r); check("bresp", {30'h0, `RESP_SLVERR}, {30'h0, r});
    code <= 2'b10;
    cyc(500); check("sleeping", 1, sleeping);
    n = 0;
    while (sleeping && n < 500) begin cyc(1); n++; end
    check("sleeping", 0, sleeping);
    done("wake");
    for (int i = 0; i < 4; i++) begin
      code <= cl[i];
      cyc(40); check_gates(gl[i]);
    end
    code <= 2'b00;
    cyc(150); check("sleeping", 1, sleeping);
    code <= 2'b10;
    cyc(700); check_gates(`GATES_FORWARD);
    done("decode");
    supply_low_lockout <= 1'b1;
    cyc(5); check_gates(`GATES_OFF);
    check("fault", 1, fault_active);
    supply_low_lockout <= 1'b0;
    cyc(40); check_gates(`GATES_FORWARD);
    thermal_shutdown <= 1'b1;
    cyc(5);
    thermal_shutdown <= 1'b0;
    cyc(40); check_gates(`GATES_OFF);
    axi_rd(`REG_STATUS, d, r); check("status", 32'h2, d);
    thermal_cooled <= 1'b1;
    cyc(40); check_gates(`GATES_FORWARD);
    thermal_cooled <= 1'b0;
    done("supply and thermal");
    overcurrent_guard <= 1'b1;
    cyc(187);
    overcurrent_guard <= 1'b0;
    cyc(3); check_gates(`GATES_FORWARD);
    oc_trip;
    check("lockout", 1, n >= LOCK - 20 && n <= LOCK);
    cyc(40); check_gates(`GATES_FORWARD);
    code <= 2'b01;
    oc_trip;
    cyc(40); check_gates(`GATES_REVERSE);
    axi_rd(`REG_TRIP_COUNT, d, r); check("trips", 32'h2, d);
    axi_wr(`REG_TRIP_COUNT, 32'h0, r);
    axi_rd(`REG_TRIP_COUNT, d, r); check("trips", 32'h0, d);
    done("overcurrent");
    code <= 2'b10;
    cyc(40);
    regulation_trip <= 1'b1;
    cyc(1);
    regulation_trip <= 1'b0;
    cyc(40); check_gates(`GATES_BRAKE);
    cyc(3200); check_gates(`GATES_FORWARD);
    axi_wr(`REG_CONTROL, 32'h2, r); check("bresp", 32'h0, {30'h0, r});
    regulation_trip <= 1'b1;
    cyc(1);
    regulation_trip <= 1'b0;
    cyc(40); check_gates(`GATES_FORWARD);
    axi_wr(`REG_STATUS, 32'hff, r); check("bresp", 32'h0, {30'h0, r});
    done("regulation");
    duty <= 4'h8;
    pwm_on <= 1'b1;
    cyc(400);
    pwm_on <= 1'b0;
    cyc(40); check_gates(`GATES_FORWARD);
    done("pwm");
    axi_wr(`REG_CONTROL, 32'h1, r); check("bresp", 32'h0, {30'h0, r});
    code <= 2'b00;
    cyc(150); check("sleeping", 0, sleeping);
    check_gates(`GATES_COAST);
    done("sleep disable");
    print_verdict;
  end
endmodule // tb
